// ===== dv/oss_source_select_monitor.sv
`timescale 1ns/10ps
module oss_chk (
    input wire i_clk,
    input wire i_nrst,
    input wire [3:0] o_osc_mode,
    input wire o_fast_internal_rc_en,
    input wire o_low_power_internal_rc_en,
    input wire o_primary_osc_en,
    input wire o_high_speed_crystal,
    input wire o_standard_crystal,
    input wire o_external_clock_input,
    input wire o_pll_en,
    input wire o_div_n_en,
    input wire o_div16_en,
    input wire o_second_osc_pin_crystal,
    input wire o_second_osc_pin_clkout,
    input wire o_second_osc_pin_oe,
    input wire o_cpu_clock_tick,
    input wire o_peripheral_clock_tick,
    input wire o_config_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire [3:0] m = o_osc_mode;
    a_mode_held: assert property (o_config_valid && $past(o_config_valid) |-> $stable(m))
        else $error("mode moved after sampling");
    a_divn_path: assert property (m == 4'h1 |-> o_div_n_en && o_fast_internal_rc_en && !o_pll_en)
        else $error("divide-by-N path wrong");
    a_div16_path: assert property (m == 4'h2 |-> o_div16_en && !o_div_n_en && !o_pll_en)
        else $error("divide-by-16 path wrong");
    a_low_power_internal_rc_path: assert property (m == 4'h3 |-> o_low_power_internal_rc_en && !o_pll_en)
        else $error("low-power source wrong");
    a_pri_pll: assert property (m inside {4'h4, 4'h5, 4'h6} |-> o_pll_en && o_primary_osc_en)
        else $error("primary with PLL wrong");
    a_pri_direct: assert property (m inside {4'h7, 4'h8, 4'h9} |-> o_primary_osc_en && !o_pll_en)
        else $error("primary direct wrong");
    a_ext_clock: assert property (m inside {4'h6, 4'h9} |-> o_external_clock_input &&
        !o_high_speed_crystal && !o_standard_crystal)
        else $error("external clock mode wrong");
    a_frc_pll: assert property (m == 4'ha |-> o_pll_en && o_div_n_en && o_fast_internal_rc_en)
        else $error("fast RC PLL path wrong");
    a_frc_plain: assert property (m == 4'h0 |-> o_fast_internal_rc_en && !o_div_n_en &&
        !o_pll_en && !o_div16_en)
        else $error("plain fast RC wrong");
    a_pin_xtal: assert property (o_second_osc_pin_crystal == (o_high_speed_crystal || o_standard_crystal))
        else $error("pin crystal role wrong");
    a_pin_drive: assert property (o_second_osc_pin_oe |-> o_second_osc_pin_clkout && !o_second_osc_pin_crystal)
        else $error("pin driven outside clock-out role");
    a_cpu_slower: assert property (o_cpu_clock_tick |-> o_peripheral_clock_tick)
        else $error("cpu tick without peripheral tick");
    a_per_full: assert property (o_config_valid && $past(o_config_valid) |-> o_peripheral_clock_tick)
        else $error("peripheral clock divided");
    c_pri_pll: cover property (m == 4'h4);
    c_frc_pll: cover property (m == 4'ha);
    c_dozing: cover property (o_peripheral_clock_tick && !o_cpu_clock_tick);
    c_clkout: cover property (o_second_osc_pin_oe);
endmodule

bind oss_source_select oss_chk u_chk (.*);

// ===== dv/oss_xtal_model.sv
`timescale 1ns/10ps
module oss_xtal_model (
    input wire i_clk,
    input wire i_pin_o,
    input wire i_pin_oe,
    output wire o_pin
);
    logic swing_q = 1'b0;
    // Crystal swing or driven pin level, never a stale level
    always @(posedge i_clk) swing_q <= ~swing_q;
    // device drives only in clock-out role
    assign o_pin = i_pin_oe ? i_pin_o : swing_q;
endmodule

// ===== dv/tb_oss_source_select.sv
`timescale 1ns/10ps
module tb_oss_source_select;
    logic i_clk = 0, i_nrst = 0, rd = 0, wr = 0, pfn = 1, x;
    logic [2:0] sel = 3'h7;
    logic [1:0] pri = 2'h3;
    logic [3:0] adr = 4'h0, be = 4'h0;
    logic [31:0] wd = 32'h0, q;
    logic [7:0] nc, np;
    wire [31:0] rdata;
    wire [3:0] mode;
    wire wreq, xtal, clko, gpio, po, poe, ct, pt, xpin;
    int err_total = 0, tests_run = 0, cyc = 0, i;
    logic [8:0] tab [0:12] = '{9'h1c1, 9'h192, 9'h163, 9'h0e4, 9'h0d5, 9'h0c6, 9'h0a7,
        9'h098, 9'h089, 9'h07a, 9'h010, 9'h120, 9'h0f0};
    oss_source_select dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_initial_osc_select_cfg(sel),
        .i_primary_osc_mode_cfg(pri), .i_second_osc_pin_pin_function_cfg(pfn), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_osc_mode(mode),
        .o_fast_internal_rc_en(), .o_low_power_internal_rc_en(), .o_primary_osc_en(),
        .o_high_speed_crystal(), .o_standard_crystal(), .o_external_clock_input(),
        .o_pll_en(), .o_div_n_en(), .o_div16_en(), .o_second_osc_pin_crystal(xtal),
        .o_second_osc_pin_clkout(clko), .o_second_osc_pin_gpio(gpio),
        .o_second_osc_pin_o(po), .o_second_osc_pin_oe(poe), .o_cpu_clock_tick(ct),
        .o_peripheral_clock_tick(pt), .o_config_valid());
    oss_xtal_model u_xtal (.i_clk(i_clk), .i_pin_o(po), .i_pin_oe(poe), .o_pin(xpin));
    initial forever #20 i_clk = ~i_clk;
    task test_done;
        begin
            $display("tests_run %0d err_total %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // Hang guard, run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            test_done;
        end
    end
    task chk(input [31:0] e, input [31:0] g, input string n);
        begin
            tests_run++;
            if (g !== e) begin
                err_total++;
                $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task bus(input [3:0] a, input w, input [31:0] d, input [3:0] b, output [31:0] r);
        begin
            @(posedge i_clk);
            adr <= a; rd <= !w; wr <= w; wd <= d; be <= b;
            do @(posedge i_clk); while (wreq !== 1'b0);
            r = rdata;
            rd <= 0; wr <= 0;
        end
    endtask
    task do_reset(input [8:0] e, input f);
        begin
            @(posedge i_clk);
            i_nrst <= 0; sel <= e[8:6]; pri <= e[5:4]; pfn <= f;
            repeat (12) @(posedge i_clk);
            chk(32'h1, {28'h0, mode}, "mode in reset");
            i_nrst <= 1;
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
        end
    endtask
    task cnt;
        begin
            nc = 0; np = 0;
            repeat (4) @(negedge i_clk);
            repeat (16) begin
                @(negedge i_clk);
                nc += ct; np += pt;
            end
        end
    endtask
    initial begin
        for (i = 0; i < 13; i++) begin
            do_reset(tab[i], i[0]);
            x = tab[i][3:0] inside {4'h4, 4'h5, 4'h7, 4'h8};
            chk({28'h0, tab[i][3:0]}, {28'h0, mode}, "mode");
            chk({29'h0, x, !x && !i[0], !x && i[0]}, {29'h0, xtal, clko, gpio}, "pin");
            if (poe === 1'b1) chk({31'h0, po}, {31'h0, xpin}, "pin level");
            bus(4'h4, 0, 0, 4'hf, q);
            chk({18'h0, i[0], tab[i][5:4], tab[i][8:6], 4'h8, tab[i][3:0]}, q & 32'h7f8f,
                "status");
            cnt;
            chk(32'h10, {24'h0, nc}, "cpu ticks");
            chk(32'h10, {24'h0, np}, "peripheral ticks");
        end
        @(posedge i_clk);
        sel <= 3'h2; pri <= 2'h1;
        repeat (4) @(negedge i_clk);
        chk(32'h0, {28'h0, mode}, "mode held");
        bus(4'h0, 0, 0, 4'hf, q);
        chk(32'h0, q, "ctrl reset");
        bus(4'h0, 1, 32'h3, 4'hf, q);
        cnt;
        chk(32'h8, {24'h0, nc}, "cpu ticks 1:2");
        chk(32'h10, {24'h0, np}, "peripheral ticks 1:2");
        bus(4'h0, 1, 32'h7, 4'hf, q);
        cnt;
        chk(32'h2, {24'h0, nc}, "cpu ticks 1:8");
        chk(32'h10, {24'h0, np}, "peripheral ticks 1:8");
        bus(4'h0, 1, 32'h0, 4'h0, q);
        bus(4'h0, 0, 0, 4'hf, q);
        chk(32'h7, q & 32'hf, "ctrl masked write");
        bus(4'h2, 0, 0, 4'hf, q);
        chk(32'h0, q, "unmapped read");
        bus(4'h0, 1, 32'h0, 4'hf, q);
        cnt;
        chk({24'h0, np}, {24'h0, nc}, "ticks after doze");
        test_done;
    end
endmodule

// ===== hdl/oss_defs.vh
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// Oscillator select field encodings
`define OSS_SEL_FRC        3'h0
`define OSS_SEL_FRC_PLL    3'h1
`define OSS_SEL_PRI        3'h2
`define OSS_SEL_PRI_PLL    3'h3
`define OSS_SEL_RESERVED   3'h4
`define OSS_SEL_LOW_POWER_INTERNAL_RC       3'h5
`define OSS_SEL_FRC_DIV16  3'h6
`define OSS_SEL_FRC_DIVN   3'h7

// Primary oscillator mode field encodings
`define OSS_PRI_EC         2'h0
`define OSS_PRI_XT         2'h1
`define OSS_PRI_HS         2'h2
`define OSS_PRI_OFF        2'h3

// Decoded oscillator modes
`define OSS_MODE_FRC       4'h0
`define OSS_MODE_FRC_DIVN  4'h1
`define OSS_MODE_FRC_DIV16 4'h2
`define OSS_MODE_LOW_POWER_INTERNAL_RC      4'h3
`define OSS_MODE_HS_PLL    4'h4
`define OSS_MODE_XT_PLL    4'h5
`define OSS_MODE_EC_PLL    4'h6
`define OSS_MODE_HS        4'h7
`define OSS_MODE_XT        4'h8
`define OSS_MODE_EC        4'h9
`define OSS_MODE_FRC_PLL   4'ha

// Erased configuration state
`define OSS_ERASED_SEL     3'h7
`define OSS_ERASED_PRI     2'h3
`define OSS_ERASED_PINFN   1'h1

// Register byte offsets
`define OSS_REG_CTRL       4'h0
`define OSS_REG_STATUS     4'h4
`define OSS_REG_PREVIEW    4'h8
`define OSS_REG_TICKS      4'hc

// Control register fields
`define OSS_CTRL_DOZE_EN   0
`define OSS_CTRL_RATIO_LSB 1
`define OSS_CTRL_RATIO_MSB 3
`define OSS_CTRL_RESET     4'h0

// Status register fields
`define OSS_ST_MODE_LSB    0
`define OSS_ST_MODE_MSB    3
`define OSS_ST_PLL         4
`define OSS_ST_DIVN        5
`define OSS_ST_DIV16       6
`define OSS_ST_SAMPLED     7
`define OSS_ST_SEL_LSB     8
`define OSS_ST_SEL_MSB     10
`define OSS_ST_PRI_LSB     11
`define OSS_ST_PRI_MSB     12
`define OSS_ST_PINFN       13
`define OSS_ST_DOZING      14

`endif

// ===== hdl/oss_source_select.v
`timescale 1ns/10ps
`include "oss_defs.vh"

module oss_source_select #(
    parameter TICK_W = 32
) (
    input wire i_clk,
    input wire i_nrst,
    input wire [2:0] i_initial_osc_select_cfg,
    input wire [1:0] i_primary_osc_mode_cfg,
    input wire i_second_osc_pin_pin_function_cfg,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    output wire [3:0] o_osc_mode,
    output wire o_fast_internal_rc_en,
    output wire o_low_power_internal_rc_en,
    output wire o_primary_osc_en,
    output wire o_high_speed_crystal,
    output wire o_standard_crystal,
    output wire o_external_clock_input,
    output wire o_pll_en,
    output wire o_div_n_en,
    output wire o_div16_en,
    output wire o_second_osc_pin_crystal,
    output wire o_second_osc_pin_clkout,
    output wire o_second_osc_pin_gpio,
    output wire o_second_osc_pin_o,
    output wire o_second_osc_pin_oe,
    output wire o_cpu_clock_tick,
    output wire o_peripheral_clock_tick,
    output wire o_config_valid
);

    localparam ST_SAMPLE = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam BUS_IDLE = 2'b01;
    localparam BUS_ACK = 2'b10;

    // Select and mode fields to a decoded oscillator mode
    function [3:0] decode_mode;
        input [2:0] sel;
        input [1:0] pri;
        begin
            case (sel)
                `OSS_SEL_FRC: decode_mode = `OSS_MODE_FRC;
                `OSS_SEL_FRC_PLL: decode_mode = `OSS_MODE_FRC_PLL;
                `OSS_SEL_PRI: begin
                    case (pri)
                        `OSS_PRI_HS: decode_mode = `OSS_MODE_HS;
                        `OSS_PRI_XT: decode_mode = `OSS_MODE_XT;
                        `OSS_PRI_EC: decode_mode = `OSS_MODE_EC;
                        // Primary disabled, stay on a running source
                        default: decode_mode = `OSS_MODE_FRC;
                    endcase
                end
                `OSS_SEL_PRI_PLL: begin
                    case (pri)
                        `OSS_PRI_HS: decode_mode = `OSS_MODE_HS_PLL;
                        `OSS_PRI_XT: decode_mode = `OSS_MODE_XT_PLL;
                        `OSS_PRI_EC: decode_mode = `OSS_MODE_EC_PLL;
                        default: decode_mode = `OSS_MODE_FRC;
                    endcase
                end
                `OSS_SEL_LOW_POWER_INTERNAL_RC: decode_mode = `OSS_MODE_LOW_POWER_INTERNAL_RC;
                `OSS_SEL_FRC_DIV16: decode_mode = `OSS_MODE_FRC_DIV16;
                `OSS_SEL_FRC_DIVN: decode_mode = `OSS_MODE_FRC_DIVN;
                default: decode_mode = `OSS_MODE_FRC;
            endcase
        end
    endfunction

    // Modes that use the PLL
    function uses_pll;
        input [3:0] mode;
        begin
            uses_pll = (mode == `OSS_MODE_HS_PLL) || (mode == `OSS_MODE_XT_PLL) ||
                (mode == `OSS_MODE_EC_PLL) || (mode == `OSS_MODE_FRC_PLL);
        end
    endfunction

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] sel_q;
    reg [1:0] pri_q;
    reg pinfn_q;
    reg [3:0] mode_q;
    reg [3:0] ctrl_q;
    reg [6:0] doze_cnt_q;
    reg [6:0] doze_cnt_d;
    reg cpu_tick_q;
    reg periph_tick_q;
    reg pin_o_q;
    reg [TICK_W-1:0] ticks_q;
    reg [1:0] bus_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    wire running;
    wire doze_on;
    wire [6:0] doze_limit;
    wire mode_crystal;
    wire mode_ec;
    wire bus_req;
    wire [3:0] live_mode;
    wire [31:0] status_word;

    assign running = state_q[1];
    assign live_mode = decode_mode(i_initial_osc_select_cfg, i_primary_osc_mode_cfg);

    always @* begin
        case (state_q)
            ST_SAMPLE: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_SAMPLE;
        endcase
    end

    // Reset holds the erased state, so decode matches before sampling
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_SAMPLE;
            sel_q <= `OSS_ERASED_SEL;
            pri_q <= `OSS_ERASED_PRI;
            pinfn_q <= `OSS_ERASED_PINFN;
            mode_q <= `OSS_MODE_FRC_DIVN;
        end else begin
            state_q <= state_d;
            if (state_q == ST_SAMPLE) begin
                sel_q <= i_initial_osc_select_cfg;
                pri_q <= i_primary_osc_mode_cfg;
                pinfn_q <= i_second_osc_pin_pin_function_cfg;
                mode_q <= live_mode;
            end
        end
    end

    assign o_osc_mode = mode_q;
    assign o_config_valid = running;

    assign o_div_n_en = (mode_q == `OSS_MODE_FRC_DIVN) || (mode_q == `OSS_MODE_FRC_PLL);
    assign o_div16_en = (mode_q == `OSS_MODE_FRC_DIV16);
    // PLL for primary and fast RC PLL modes
    assign o_pll_en = uses_pll(mode_q);
    // low-power RC only in its own mode
    assign o_low_power_internal_rc_en = (mode_q == `OSS_MODE_LOW_POWER_INTERNAL_RC);
    assign o_fast_internal_rc_en = (mode_q == `OSS_MODE_FRC) || o_div_n_en || o_div16_en;
    assign o_primary_osc_en = (mode_q == `OSS_MODE_HS) || (mode_q == `OSS_MODE_XT) ||
        mode_ec || (mode_q == `OSS_MODE_HS_PLL) || (mode_q == `OSS_MODE_XT_PLL);
    assign o_high_speed_crystal = (mode_q == `OSS_MODE_HS) || (mode_q == `OSS_MODE_HS_PLL);
    assign o_standard_crystal = (mode_q == `OSS_MODE_XT) || (mode_q == `OSS_MODE_XT_PLL);
    assign mode_ec = (mode_q == `OSS_MODE_EC) || (mode_q == `OSS_MODE_EC_PLL);
    assign o_external_clock_input = mode_ec;
    assign mode_crystal = o_high_speed_crystal || o_standard_crystal;

    // pin role from function bit unless crystal
    assign o_second_osc_pin_crystal = mode_crystal;
    assign o_second_osc_pin_clkout = !mode_crystal && !pinfn_q;
    assign o_second_osc_pin_gpio = !mode_crystal && pinfn_q;
    assign o_second_osc_pin_oe = o_second_osc_pin_clkout;
    assign o_second_osc_pin_o = pin_o_q;

    // Doze divides by two to the ratio code
    assign doze_on = ctrl_q[`OSS_CTRL_DOZE_EN] && (ctrl_q[3:1] != 3'h0);
    assign doze_limit = (7'h01 << ctrl_q[3:1]) - 7'h01;

    // only the CPU tick is thinned
    always @* begin
        if (!running || !doze_on || (doze_cnt_q >= doze_limit)) begin
            doze_cnt_d = 7'h00;
        end else begin
            doze_cnt_d = doze_cnt_q + 7'h01;
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            doze_cnt_q <= 7'h00;
            cpu_tick_q <= 1'b0;
            periph_tick_q <= 1'b0;
            pin_o_q <= 1'b0;
            ticks_q <= {TICK_W{1'b0}};
        end else begin
            doze_cnt_q <= doze_cnt_d;
            // equal ticks when doze is off
            periph_tick_q <= running;
            cpu_tick_q <= running && (!doze_on || (doze_cnt_q >= doze_limit));
            // Pin shows CPU clock, halved per tick
            if (cpu_tick_q) begin
                pin_o_q <= !pin_o_q;
            end
            if (cpu_tick_q) begin
                ticks_q <= ticks_q + {{(TICK_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign o_cpu_clock_tick = cpu_tick_q;
    assign o_peripheral_clock_tick = periph_tick_q;

    // One wait cycle lets read data come from a flip-flop
    assign bus_req = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = bus_req && !bus_q[1];
    assign o_avs_readdata = rdata_q;

    assign status_word = {17'h0, doze_on, pinfn_q, pri_q, sel_q, running,
        o_div16_en, o_div_n_en, o_pll_en, mode_q};

    always @* begin
        case (i_avs_address)
            `OSS_REG_CTRL: rdata_d = {28'h0, ctrl_q};
            `OSS_REG_STATUS: rdata_d = status_word;
            `OSS_REG_PREVIEW: rdata_d = {24'h0, uses_pll(live_mode), i_second_osc_pin_pin_function_cfg,
                i_primary_osc_mode_cfg, i_initial_osc_select_cfg, live_mode[0]};
            `OSS_REG_TICKS: rdata_d = ticks_q[31:0];
            // Unmapped reads return zero
            default: rdata_d = 32'h0;
        endcase
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_q <= BUS_IDLE;
            rdata_q <= 32'h0;
            ctrl_q <= `OSS_CTRL_RESET;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_q <= BUS_ACK;
                        rdata_q <= rdata_d;
                    end
                end
                BUS_ACK: begin
                    bus_q <= BUS_IDLE;
                    // Write lands on the accepting edge
                    if (i_avs_write && (i_avs_address == `OSS_REG_CTRL) &&
                        i_avs_byteenable[0]) begin
                        ctrl_q <= i_avs_writedata[3:0];
                    end
                end
                default: bus_q <= BUS_IDLE;
            endcase
        end
    end

endmodule
